// file: src/scan_mode_defs.svh
// Purpose: Offsets, field positions, reset values and timing for the scan mode block
// Assumes: 32-bit classic Wishbone, 50 MHz clock
// Notes:   Included by its bare name; definitions only
`ifndef SCAN_MODE_DEFS_SVH
`define SCAN_MODE_DEFS_SVH

// Register byte offsets
`define REG_CTRL          8'h00
`define REG_CFG           8'h04
`define REG_STATUS        8'h08
`define REG_RESULT0       8'h0C
`define REG_RESULT1       8'h10

// Control register fields
`define CTRL_TRIG_SERIAL  0
`define CTRL_SW_START     1
`define CTRL_SW_STOP      2
`define CTRL_EVAL         3
`define CTRL_REFUSED      4

// Configuration register fields
`define CFG_AF_EN         0
`define CFG_AF_MODE       1
`define CFG_MIRROR        3
`define CFG_DEC_STD       5
`define CFG_DIST          8
`define CFG_ANGLE         16
`define CFG_RESET         32'h0000_0101

// Timing, in the unit given by the name
`define CLK_PERIOD_NS     20
`define MS_NS             1000000
`define READ_LED_MS       16'h0064
`define EVAL_PERIOD_MS    16'h07D0
`define FOCUS_TIMEOUT_MS  6'h1E
`define BLINK2_HALF_MS    16'h00FA
`define BLINK5_HALF_MS    16'h0064

// Evaluation figures
`define SCANS_PER_EVAL    7'h64
`define PARK_ANGLE        7'h32
`define QUAL_LOW          7'h1E
`define QUAL_MID          7'h46
`define QUAL_HIGH         7'h5A

`endif

// file: src/scan_mode_pkg.sv
// Purpose: Types shared by the scan mode block and its bench
// Assumes: Constants live in scan_mode_defs.svh
// Notes:   Enums carry no explicit codes
package scan_mode_pkg;

  typedef enum logic [1:0] {AF_MIN_DIST, AF_DIFF_BG, AF_TRACKING, AF_FIXED} af_mode_type;
  typedef enum logic [1:0] {MIRROR_OSC, MIRROR_ONESHOT, MIRROR_FIXED, MIRROR_SPARE} mirror_mode_type;
  typedef enum logic {MODE_READ, MODE_EVAL} dev_mode_type;
  typedef enum logic [1:0] {LED_OFF, LED_BLINK2, LED_BLINK5, LED_ON} led_pattern_type;

  typedef struct packed {
    logic [3:0]  read_status;
    logic [15:0] interval_duration;
    logic [6:0]  mean_quality;
    logic [7:0]  code_count;
    logic [2:0]  distance_config_number;
  } result_type;

  typedef struct packed {
    logic        osc_en;
    logic [6:0]  scan_angle_value;
    af_mode_type af_mode;
    logic [5:0]  focus_timeout_ms;
    logic        pref_last_object;
  } scan_setup_type;

endpackage : scan_mode_pkg

// file: src/scan_trigger_eval.sv
// Purpose: Reading trigger and percentage evaluation control for a line scanner
// Assumes: Inputs synchronous to clk; decoder reports one scan per scan_done pulse
// Notes:   Settings written here are volatile and return to defaults on reset
// Behaviour
// [RQ1] After reset the reading trigger comes from the sensor switching input.
// [RQ2] Serial trigger source, once selected, accepts start/stop until reset; code reverts to sensor on any CTRL write to byte 0 with bit 0 clear.
// [RQ3] Start command opens interval, lights sensor LED, enables scan line.
// [RQ4] Stop command closes interval, sensor LED off, laser off, result sent.
// [RQ5] After a result the read-result LED lights for 100 ms.
// [RQ6] Evaluation runs free, grouping 100 scans per quality figure.
// [RQ7] Evaluation emits one result every 2 s.
// [RQ8] All four result outputs stay inactive during evaluation.
// [RQ9] Host selects the standard decoder before entering evaluation.
// [RQ10] With autofocus, evaluation starts only in minimum distance or differential background; code also accepts tracking, refusing only fixed.
// [RQ11] Evaluation with autofocus fixes focus timeout 30 ms, prefers last object.
// [RQ12] Tracking autofocus runs as plain differential background during evaluation.
// [RQ13] Oscillating mirror stops and parks at angle value 50 during evaluation.
// [RQ14] One-shot mirror also parks at angle value 50 during evaluation.
// [RQ15] Fixed mirror position stays unchanged during evaluation.
// [RQ16] Entering evaluation extinguishes device-ready and starts continuous output.
// [RQ17] Read LED: off <30%, 2 Hz blink to 70%, 5 Hz to 90%, steady above.
// [RQ18] Evaluation results use the same record as reading mode.
// [RQ19] With autofocus the host picks distance configuration 1 for evaluation.
// [RQ20] Minimum distance focus targets the nearest object during evaluation.
// [RQ21] Record holds read status (0 = good), duration, quality, codes, configuration.
// [RQ22] LED pattern follows the last completed evaluation at each emitted result.
// [RQ23] Leaving evaluation restores mirror, focus, trigger and relights device-ready; code sets the trigger source from bit 0 of the exiting CTRL write.
`timescale 1ns/1ns
`include "scan_mode_defs.svh"

module scan_trigger_eval
  import scan_mode_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `MS_NS / `CLK_PERIOD_NS
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Switching input and decoder feedback
  input  wire logic        sensor_in,
  input  wire logic        scan_done,
  input  wire logic        scan_good,
  input  wire logic [6:0]  scan_quality,
  input  wire logic [7:0]  scan_codes,
  // Optics and indicators
  output logic             laser_on,
  output logic             sensor_led,
  output logic             read_led,
  output logic             ready_led,
  output logic      [3:0]  result_out,
  output scan_setup_type   scan_setup,
  // Result record towards the terminal interface
  output logic             result_valid,
  input  wire logic        result_ready,
  output result_type       result
);

  dev_mode_type    mode_q;
  led_pattern_type pattern_q;
  mirror_mode_type cfg_mirror;
  af_mode_type     cfg_af;
  logic [31:0]     cfg_q;
  logic [31:0]     rd_data;
  logic            trig_serial_q;
  logic            refused_q;
  logic            ack_q;
  logic            interval_q;
  logic            sensor_prev_q;
  logic            valid_q;
  logic [15:0]     ms_cnt_q;
  logic            ms_tick;
  logic [15:0]     dur_q;
  logic [15:0]     period_q;
  logic [15:0]     led_ms_q;
  logic [15:0]     blink_ms_q;
  logic            blink_q;
  logic            good_any_q;
  logic [6:0]      qual_q;
  logic [7:0]      codes_q;
  logic [6:0]      scan_cnt_q;
  logic [6:0]      good_cnt_q;
  logic [6:0]      last_pct_q;
  result_type      result_q;
  scan_setup_type  setup_q;
  logic            req;
  logic            wr;
  logic            wr_ctrl;
  logic            eval_allowed;
  logic            start_evt;
  logic            stop_evt;
  logic            emit_eval;
  logic            set_refused;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction : hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = m;
  endfunction : merge

  function automatic led_pattern_type quality_pattern(input logic [6:0] pct);
    if (pct < `QUAL_LOW)
    begin
      quality_pattern = LED_OFF;
    end
    else if (pct <= `QUAL_MID)
    begin
      quality_pattern = LED_BLINK2;
    end
    else if (pct <= `QUAL_HIGH)
    begin
      quality_pattern = LED_BLINK5;
    end
    else
    begin
      quality_pattern = LED_ON;
    end
  endfunction : quality_pattern

  assign cfg_mirror = mirror_mode_type'(cfg_q[`CFG_MIRROR +: 2]);
  assign cfg_af     = af_mode_type'(cfg_q[`CFG_AF_MODE +: 2]);
  assign req        = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr         = req & wb_we_i;
  assign wr_ctrl    = wr & hit(wb_adr_i, `REG_CTRL) & wb_sel_i[0];
  assign ms_tick    = (ms_cnt_q == 16'(MS_CYCLES - 1));

  // Fixed focus is refused when autofocus is enabled; tracking is accepted and demoted below
  assign eval_allowed = cfg_q[`CFG_DEC_STD]                                      // see [RQ9]
                      & (~cfg_q[`CFG_AF_EN] | (cfg_af != AF_FIXED));             // see [RQ10]

  // Host start/stop commands count only while the serial port owns the trigger
  assign start_evt = (mode_q == MODE_READ) & ~interval_q
                   & (trig_serial_q ? (wr_ctrl & wb_dat_i[`CTRL_SW_START])       // see [RQ2]
                                    : (sensor_in & ~sensor_prev_q));             // see [RQ1]
  assign stop_evt  = (mode_q == MODE_READ) & interval_q
                   & (trig_serial_q ? (wr_ctrl & wb_dat_i[`CTRL_SW_STOP])
                                    : (~sensor_in & sensor_prev_q));
  assign emit_eval = (mode_q == MODE_EVAL) & ms_tick & (period_q == `EVAL_PERIOD_MS - 16'h0001);
  assign set_refused = wr_ctrl & wb_dat_i[`CTRL_EVAL] & (mode_q == MODE_READ) & ~eval_allowed;

  // Wishbone: one wait state, ack for every address, unmapped reads return zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_q    <= req;
      wb_dat_o <= req ? rd_data : wb_dat_o;
    end
  end

  assign wb_ack_o = ack_q;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit(wb_adr_i, `REG_CTRL))
    begin
      rd_data = {27'h0, refused_q, mode_q == MODE_EVAL, 2'h0, trig_serial_q};
    end
    else if (hit(wb_adr_i, `REG_CFG))
    begin
      rd_data = cfg_q;
    end
    else if (hit(wb_adr_i, `REG_STATUS))
    begin
      rd_data = {16'h0, 1'b0, last_pct_q, pattern_q, ready_led, read_led, sensor_led, laser_on,
                 mode_q == MODE_EVAL, interval_q};
    end
    else if (hit(wb_adr_i, `REG_RESULT0))
    begin
      rd_data = {result_q.interval_duration, 12'h0, result_q.read_status};
    end
    else if (hit(wb_adr_i, `REG_RESULT1))
    begin
      rd_data = {9'h0, result_q.mean_quality, result_q.code_count, 5'h0, result_q.distance_config_number};
    end
  end

  // Volatile settings: a reset is the power cycle that reverts them
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_serial_q <= 1'b0;                                                     // see [RQ1]
      cfg_q         <= `CFG_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        trig_serial_q <= wb_dat_i[`CTRL_TRIG_SERIAL];                            // see [RQ2]
      end
      if (wr & hit(wb_adr_i, `REG_CFG))
      begin
        cfg_q <= merge(cfg_q, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Mode: leaving evaluation simply stops the overrides, so stored settings reappear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q    <= MODE_READ;
      refused_q <= 1'b0;
    end
    else
    begin
      if (wr_ctrl & wb_dat_i[`CTRL_EVAL] & (mode_q == MODE_READ) & eval_allowed)
      begin
        mode_q <= MODE_EVAL;                                                     // see [RQ16]
      end
      else if (wr_ctrl & ~wb_dat_i[`CTRL_EVAL])
      begin
        mode_q <= MODE_READ;                                                     // see [RQ23]
      end
      // A new refusal wins over a clear written in the same cycle
      if (set_refused)
      begin
        refused_q <= 1'b1;
      end
      else if (wr_ctrl & wb_dat_i[`CTRL_REFUSED])
      begin
        refused_q <= 1'b0;
      end
    end
  end

  // Millisecond time base shared by every timer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_cnt_q <= 16'h0000;
    end
    else
    begin
      ms_cnt_q <= ms_tick ? 16'h0000 : ms_cnt_q + 16'h0001;
    end
  end

  // Reading interval
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      interval_q    <= 1'b0;
      sensor_prev_q <= 1'b0;
      dur_q         <= 16'h0000;
    end
    else
    begin
      sensor_prev_q <= sensor_in;
      if (start_evt)
      begin
        interval_q <= 1'b1;                                                      // see [RQ3]
        dur_q      <= 16'h0000;
      end
      else if (stop_evt | (mode_q == MODE_EVAL))
      begin
        interval_q <= 1'b0;                                                      // see [RQ4]
      end
      else if (interval_q & ms_tick & (dur_q != 16'hFFFF))
      begin
        dur_q <= dur_q + 16'h0001;
      end
    end
  end

  // Scan statistics: per interval in reading mode, per 100 scans in evaluation
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      good_any_q <= 1'b0;
      qual_q     <= 7'h00;
      codes_q    <= 8'h00;
      scan_cnt_q <= 7'h00;
      good_cnt_q <= 7'h00;
      last_pct_q <= 7'h00;
    end
    else
    begin
      if (start_evt)
      begin
        good_any_q <= 1'b0;
        codes_q    <= 8'h00;
      end
      else if (scan_done)
      begin
        good_any_q <= good_any_q | scan_good;
        qual_q     <= scan_quality;
        codes_q    <= scan_good ? scan_codes : codes_q;
      end
      if (mode_q != MODE_EVAL)
      begin
        scan_cnt_q <= 7'h00;
        good_cnt_q <= 7'h00;
      end
      else if (scan_done & (scan_cnt_q == `SCANS_PER_EVAL - 7'h01))
      begin
        last_pct_q <= good_cnt_q + 7'(scan_good);                                // see [RQ6]
        scan_cnt_q <= 7'h00;
        good_cnt_q <= 7'h00;
      end
      else if (scan_done)
      begin
        scan_cnt_q <= scan_cnt_q + 7'h01;
        good_cnt_q <= good_cnt_q + 7'(scan_good);
      end
    end
  end

  // Result record and its hand-off; an unaccepted record is overwritten by the next
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_q  <= '0;
      valid_q   <= 1'b0;
      period_q  <= 16'h0000;
      pattern_q <= LED_OFF;
    end
    else
    begin
      if (mode_q != MODE_EVAL)
      begin
        period_q <= 16'h0000;
      end
      else if (ms_tick)
      begin
        period_q <= emit_eval ? 16'h0000 : period_q + 16'h0001;                  // see [RQ7]
      end
      if (stop_evt)
      begin
        result_q.read_status            <= good_any_q ? 4'h0 : 4'h1;             // see [RQ21]
        result_q.interval_duration      <= dur_q;
        result_q.mean_quality           <= qual_q;
        result_q.code_count             <= codes_q;
        result_q.distance_config_number <= cfg_q[`CFG_DIST +: 3];
        valid_q                         <= 1'b1;                                 // see [RQ4]
      end
      else if (emit_eval)
      begin
        result_q.read_status            <= (last_pct_q != 7'h00) ? 4'h0 : 4'h1;  // see [RQ18]
        result_q.interval_duration      <= `EVAL_PERIOD_MS;
        result_q.mean_quality           <= last_pct_q;
        result_q.code_count             <= codes_q;
        result_q.distance_config_number <= cfg_q[`CFG_DIST +: 3];                // see [RQ19]
        valid_q                         <= 1'b1;                                 // see [RQ16]
        pattern_q                       <= quality_pattern(last_pct_q);          // see [RQ22]
      end
      else if (result_ready)
      begin
        valid_q <= 1'b0;
      end
    end
  end

  assign result_valid = valid_q;
  assign result       = result_q;

  // Read-result LED timers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      led_ms_q   <= 16'h0000;
      blink_ms_q <= 16'h0000;
      blink_q    <= 1'b0;
    end
    else
    begin
      if (stop_evt)
      begin
        led_ms_q <= `READ_LED_MS;                                                // see [RQ5]
      end
      else if (ms_tick & (led_ms_q != 16'h0000))
      begin
        led_ms_q <= led_ms_q - 16'h0001;
      end
      if (ms_tick)
      begin
        if (blink_ms_q >= ((pattern_q == LED_BLINK2) ? `BLINK2_HALF_MS : `BLINK5_HALF_MS) - 16'h0001)
        begin
          blink_ms_q <= 16'h0000;
          blink_q    <= ~blink_q;                                                // see [RQ17]
        end
        else
        begin
          blink_ms_q <= blink_ms_q + 16'h0001;
        end
      end
    end
  end

  // Optics overrides; recomputed every cycle so exit restores stored settings one cycle later
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      setup_q <= '0;
    end
    else
    begin
      setup_q.osc_en           <= (mode_q == MODE_READ) & (cfg_mirror == MIRROR_OSC);  // see [RQ13]
      setup_q.scan_angle_value <= ((mode_q == MODE_EVAL) & (cfg_mirror != MIRROR_FIXED))
                                  ? `PARK_ANGLE : cfg_q[`CFG_ANGLE +: 7];        // see [RQ14] see [RQ15]
      setup_q.af_mode          <= ((mode_q == MODE_EVAL) & (cfg_af == AF_TRACKING))
                                  ? AF_DIFF_BG : cfg_af;                         // see [RQ12] see [RQ20]
      setup_q.focus_timeout_ms <= ((mode_q == MODE_EVAL) & cfg_q[`CFG_AF_EN])
                                  ? `FOCUS_TIMEOUT_MS : 6'h00;                   // see [RQ11]
      setup_q.pref_last_object <= (mode_q == MODE_EVAL) & cfg_q[`CFG_AF_EN];     // see [RQ11]
    end
  end

  assign scan_setup = setup_q;
  assign laser_on   = interval_q | (mode_q == MODE_EVAL);                        // see [RQ3] see [RQ6]
  assign sensor_led = interval_q;
  assign ready_led  = (mode_q == MODE_READ);                                     // see [RQ16] see [RQ23]

  always_comb
  begin
    read_led   = 1'b0;
    result_out = 4'h0;                                                           // see [RQ8]
    if (mode_q == MODE_EVAL)
    begin
      case (pattern_q)
        LED_OFF:    read_led = 1'b0;
        LED_BLINK2: read_led = blink_q;
        LED_BLINK5: read_led = blink_q;
        LED_ON:     read_led = 1'b1;
        default:    read_led = 1'b0;
      endcase
    end
    else if (led_ms_q != 16'h0000)
    begin
      read_led   = 1'b1;
      result_out = {2'h0, result_q.read_status != 4'h0, result_q.read_status == 4'h0};
    end
  end

endmodule : scan_trigger_eval

// file: dv/scan_trigger_eval_properties.sv
// Purpose: Port-level properties of the scan trigger and evaluation block
// Assumes: One clock domain, async reset rst_n
// Notes:   Bound to every instance of the design
`timescale 1ns/1ns
module scan_trigger_eval_properties
  import scan_mode_pkg::*;
#(
  parameter int unsigned MS_CYCLES = 50000
)
(
  // Clock and reset
  input wire logic           clk,
  input wire logic           rst_n,
  // Bus handshake
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_ack_o,
  // Optics, indicators, records
  input wire logic           laser_on,
  input wire logic           sensor_led,
  input wire logic           read_led,
  input wire logic           ready_led,
  input wire logic [3:0]     result_out,
  input wire scan_setup_type scan_setup,
  input wire logic           result_valid,
  input wire logic           result_ready,
  input wire result_type     result
);
  int unsigned led_cnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Length of the current read LED pulse in cycles
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      led_cnt_q <= 0;
    else
      led_cnt_q <= read_led ? led_cnt_q + 1 : 0;
  end

  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  a_eval_outputs_off: assert property (!ready_led |-> result_out == 4'h0)
    else $error("result outputs live during evaluation");
  a_interval_laser: assert property (sensor_led |-> laser_on)
    else $error("interval open with laser off");
  a_eval_no_osc: assert property (!ready_led [*2] |-> !scan_setup.osc_en)
    else $error("mirror oscillating during evaluation");
  a_eval_no_tracking: assert property (!ready_led [*2] |-> scan_setup.af_mode != AF_TRACKING)
    else $error("tracking focus during evaluation");
  a_read_focus_stored: assert property (ready_led [*2] |-> scan_setup.focus_timeout_ms == 6'h00)
    else $error("focus timeout forced in reading mode");
  a_eval_laser_on: assert property (!ready_led [*2] |-> laser_on)
    else $error("laser off during evaluation");
  a_result_held: assert property (result_valid && !result_ready |=> result_valid && $stable(result))
    else $error("record withdrawn or changed before taken");
  a_result_done: assert property (result_valid && result_ready |=> !result_valid)
    else $error("record valid after being taken");
  a_led_duration: assert property ($fell(read_led) && ready_led && $past(ready_led, 3)
    |-> led_cnt_q >= 99 * MS_CYCLES && led_cnt_q <= 100 * MS_CYCLES + 1)
    else $error("read LED pulse length wrong");

  c_eval_entry: cover property ($fell(ready_led));
  c_record_taken: cover property (result_valid && result_ready);
  c_interval_open: cover property ($rose(sensor_led));
endmodule : scan_trigger_eval_properties

bind scan_trigger_eval scan_trigger_eval_properties #(.MS_CYCLES(MS_CYCLES)) scan_trigger_eval_properties_i (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .laser_on(laser_on), .sensor_led(sensor_led), .read_led(read_led), .ready_led(ready_led),
  .result_out(result_out), .scan_setup(scan_setup), .result_valid(result_valid),
  .result_ready(result_ready), .result(result));

// file: dv/host_term_model.sv
// Purpose: Host terminal model that takes result records
// Assumes: Records use the valid/ready handshake on clk
// Notes:   STALL sets how long the host waits before taking a record
`timescale 1ns/1ns
module host_term_model
  import scan_mode_pkg::*;
#(
  parameter int unsigned STALL = 3
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Record stream
  input  wire logic       result_valid,
  input  wire result_type result,
  output logic            result_ready,
  output result_type      last_rec,
  output int unsigned     n_rec
);
  int unsigned wait_q;

  // A slow host keeps ready low, so the record has to stand meanwhile
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_ready <= 1'b0;
      wait_q       <= 0;
      n_rec        <= 0;
      last_rec     <= '0;
    end
    else if (result_valid && result_ready)
    begin
      last_rec     <= result;
      n_rec        <= n_rec + 1;
      result_ready <= 1'b0;
      wait_q       <= 0;
    end
    else if (result_valid)
    begin
      wait_q       <= wait_q + 1;
      result_ready <= (wait_q + 1 >= STALL);
    end
  end
endmodule : host_term_model

// file: dv/tb_top.sv
// Purpose: Self-checking bench for the scan trigger and evaluation block
// Assumes: MS_CYCLES of 10, so one millisecond is 10 cycles
// Notes:   Register access over classic Wishbone
`timescale 1ns/1ns
`include "scan_mode_defs.svh"
module tb_top;
  import scan_mode_pkg::*;
  localparam int unsigned MS = 10;
  logic           clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           wb_cyc_i = 1'b0;
  logic           wb_stb_i = 1'b0;
  logic           wb_we_i = 1'b0;
  logic [7:0]     wb_adr_i = 8'h00;
  logic [31:0]    wb_dat_i = 32'h0;
  logic [31:0]    wb_dat_o;
  logic           wb_ack_o;
  logic           sensor_in = 1'b0;
  logic           scan_done = 1'b0;
  logic           scan_good = 1'b0;
  logic           laser_on, sensor_led, read_led, ready_led, result_valid, result_ready;
  logic [3:0]     result_out;
  scan_setup_type scan_setup;
  result_type     result, last_rec;
  int unsigned    n_rec;
  int             err_count = 0;
  int             tests_run = 0;
  int             t0;
  logic [31:0]    q;
  logic [31:0]    cfg [3] = '{32'h0000_0125, 32'h0020_0129, 32'h0020_0133};
  logic [6:0]     ang [3] = '{7'h32, 7'h32, 7'h20};
  af_mode_type    afm [3] = '{AF_DIFF_BG, AF_MIN_DIST, AF_DIFF_BG};
  int             good [3] = '{20, 50, 100};

  always #10 clk = ~clk;

  scan_trigger_eval #(.MS_CYCLES(MS)) scan_trigger_eval_i (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sensor_in(sensor_in), .scan_done(scan_done), .scan_good(scan_good), .scan_quality(7'h50),
    .scan_codes(8'h01), .laser_on(laser_on), .sensor_led(sensor_led), .read_led(read_led),
    .ready_led(ready_led), .result_out(result_out), .scan_setup(scan_setup),
    .result_valid(result_valid), .result_ready(result_ready), .result(result));

  host_term_model #(.STALL(3)) host_term_model_i (
    .clk(clk), .rst_n(rst_n), .result_valid(result_valid), .result(result),
    .result_ready(result_ready), .last_rec(last_rec), .n_rec(n_rec));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until ack is sampled, then idles one cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    q = wb_dat_o;
    if (n >= 50)
      chk(32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic scans(input int ng);
    for (int i = 0; i < 100; i++)
    begin
      scan_done <= 1'b1;
      scan_good <= (i < ng);
      @(posedge clk);
      scan_done <= 1'b0;
      @(posedge clk);
    end
  endtask : scans

  task automatic wait_rec(input int want);
    int n;
    n = 0;
    while (n_rec < want && n < 25000)
    begin
      @(posedge clk);
      n++;
    end
    chk(n_rec, want);
  endtask : wait_rec

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, `REG_CFG, 0); chk(q, `CFG_RESET);
    wb(1'b0, `REG_STATUS, 0); chk(q, 32'h20);
    wb(1'b0, 8'h20, 0); chk(q, 32'h0);
    sensor_in <= 1'b1;
    repeat (3) @(posedge clk); chk(sensor_led, 1);
    sensor_in <= 1'b0;
    wait_rec(1); chk(last_rec.read_status, 4'h1);
    chk({read_led, result_out}, 5'h12);
    repeat (1100) @(posedge clk); chk(read_led, 0);
    wb(1'b1, `REG_CTRL, 32'h1);
    sensor_in <= 1'b1;
    repeat (3) @(posedge clk); chk(sensor_led, 0);
    sensor_in <= 1'b0;
    wb(1'b1, `REG_CTRL, 32'h3); chk({sensor_led, laser_on}, 2'b11);
    scans(3);
    wb(1'b1, `REG_CTRL, 32'h5); chk({sensor_led, laser_on}, 2'b00);
    wait_rec(2); chk(last_rec.read_status, 4'h0);
    chk({last_rec.mean_quality, last_rec.distance_config_number}, 10'h281);
    repeat (1100) @(posedge clk);
    wb(1'b1, `REG_CFG, 32'h0000_0127);
    wb(1'b1, `REG_CTRL, 32'h9);
    wb(1'b0, `REG_CTRL, 0); chk(q, 32'h11);
    chk(ready_led, 1);
    for (int i = 0; i < 3; i++)
    begin
      wb(1'b1, `REG_CFG, cfg[i]);
      wb(1'b1, `REG_CTRL, 32'h18);
      repeat (2) @(posedge clk);
      chk(ready_led, 0);
      chk({scan_setup.osc_en, scan_setup.scan_angle_value}, {1'b0, ang[i]});
      chk(scan_setup.af_mode, afm[i]);
      chk({scan_setup.focus_timeout_ms, scan_setup.pref_last_object}, {`FOCUS_TIMEOUT_MS, 1'b1});
      for (int j = 0; j < 3 && i == 0; j++)
      begin
        scans(good[j]);
        wait_rec(3 + j);
        if (j > 0)
          chk($time / 20 - t0, 2000 * MS);
        t0 = $time / 20;
        chk({last_rec.read_status, last_rec.mean_quality}, {4'h0, 7'(good[j])});
        wb(1'b0, `REG_STATUS, 0); chk(q[7:6], (j == 0) ? 0 : (j == 1) ? 1 : 3);
        if (j != 1)
          chk(read_led, j == 2);
      end
      wb(1'b1, `REG_CTRL, 32'h0);
      repeat (2) @(posedge clk);
      chk({ready_led, scan_setup.osc_en, scan_setup.af_mode}, {1'b1, cfg[i][4:3] == 0, cfg[i][2:1]});
    end
    wb(1'b1, `REG_CTRL, 32'h1);
    rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    wb(1'b0, `REG_CTRL, 0); chk(q, 32'h0);
    wb(1'b0, `REG_CFG, 0); chk(q, `CFG_RESET);
    end_of_test();
  end
endmodule : tb_top
